// File: design/asf_fifo.sv
// Result FIFO held in flip-flops
`timescale 1ns/1ps
module asf_fifo #(
  parameter int W = 12,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Discard everything, a push in the same cycle survives
  input wire logic flush,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(D):0] count
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = (count != D[AW:0]) || flush;
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready && !flush;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[flush ? '0 : wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush) begin
      rd_ptr <= '0;
      wr_ptr <= push ? AW'(1) : '0;
      count <= push ? (AW+1)'(1) : '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + AW'(1);
      if (pop) rd_ptr <= rd_ptr + AW'(1);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : asf_fifo

// File: design/asf_pkg.sv
// Shared constants of the converter sequencer
package asf_pkg;
  // Clock and time figures
  localparam int CLK_KHZ = 50000;
  localparam int OSC_MIN_KHZ = 3600;
  localparam int OSC_CYC = CLK_KHZ / OSC_MIN_KHZ;
  localparam int WARM_MS = 20;
  localparam int WARM_CYC = WARM_MS * CLK_KHZ;
  localparam logic [3:0] CONV_LAST = 4'hD;
  localparam logic [4:0] WORD_LAST = 5'h0F;
  localparam logic [4:0] SAMPLE_BIT = 5'h04;
  localparam int FIFO_W = 12;
  localparam int FIFO_D = 8;
  // Serial command codes, upper nibble of the word, and the whole software power-down word
  localparam logic [3:0] CMD_READ_CFG = 4'h9;
  localparam logic [3:0] CMD_WRITE_CFG = 4'hA;
  localparam logic [3:0] CMD_READ_FIFO = 4'hE;
  localparam logic [15:0] WORD_SOFT_PD = 16'h8000;
  // Configuration word fields
  localparam int CF_THR = 0;
  localparam int CF_EOC = 2;
  localparam int CF_SEQ = 3;
  localparam int CF_MODE = 5;
  localparam int CF_REF4 = 7;
  localparam int CF_REFEXT = 8;
  localparam int CF_EXT = 9;
  localparam int CF_CLK = 10;
  localparam logic [11:0] CFG_RESET = 12'h000;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_REPEAT = 2'h1;
  localparam logic [1:0] MODE_SWEEP = 2'h2;
  localparam logic [1:0] MODE_RSWEEP = 2'h3;
  // Sweep tables, four channels of three bits, first channel in low bits
  localparam logic [47:0] SWEEP_TAB = 48'h688_B18_440_688;
  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'b000,
    PWR_AUTO = 3'b001,
    PWR_SOFT = 3'b010,
    PWR_HARD = 3'b011,
    PWR_WARM = 3'b100
  } asf_pwr_t;
endpackage : asf_pkg

// File: design/asf_seq.sv
// Converter control: serial commands, sampling, conversion, FIFO, power
//
// Behaviour
// [RULE_01] A configuration write loads 12 bits, never converts nor signals.
// [RULE_02] Single shot extended: conversion starts on next trigger rising edge.
// [RULE_03] Host keeps select cycle at least 6 SCLKs, same before trigger.
// [RULE_04] Trigger low time outside chip select low is the sampling window.
// [RULE_05] Results go into an 8-entry FIFO with configured threshold.
// [RULE_06] Interrupt asserts when stored results reach the threshold.
// [RULE_07] FIFO filled from fixed channel or sweep sequence, by mode.
// [RULE_08] Single shot forces depth one and ignores threshold bits.
// [RULE_09] A conversion takes 14 conversion clocks; oscillator at least 3.6 MHz.
// [RULE_10] SCLK source divided by 1, 2 or 4 as configured.
// [RULE_11] Host keeps divided SCLK conversion clock at or below 6 MHz.
// [RULE_12] Auto power-down after every conversion, reference stays on.
// [RULE_13] Chip select, frame sync or trigger wake auto power-down at once.
// [RULE_14] Word 8000h enters software power-down including reference.
// [RULE_15] Power-down pin powers down; release warms 20 ms if internal ref.
// [RULE_16] Activity leaves software power-down, 20 ms warm-up if internal ref.
// [RULE_17] Power-down keeps configuration but restarts the sweep.
// [RULE_18] Power-down empties the result FIFO.
// [RULE_19] Configuration picks internal or external reference, 2 V or 4 V.
// [RULE_20] Mode field: single shot, repeat, sweep, repeated sweep.
// [RULE_21] Completion pin is end of conversion only in single shot.
// [RULE_22] First command after interrupt outputs FIFO head; non-read keeps it.
// [RULE_23] Non-read after interrupt or new trigger clears FIFO before next store.
// [RULE_24] Interrupt drops when the host starts the next cycle or FIFO clears.
`timescale 1ns/1ps
module asf_seq #(
  parameter int unsigned WARMUP_CYCLES = asf_pkg::WARM_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Serial port from the host
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic frame_sync_in,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // Control pins
  input wire logic ext_sample_trigger_n,
  input wire logic hw_powerdown_n,
  output logic completion_n,
  // Analogue front end
  input wire logic [11:0] adc_result,
  output logic [2:0] mux_channel,
  output logic sampling,
  output logic converting,
  output logic analog_powered,
  output logic ref_powered,
  output logic ref_level_4v,
  output logic ref_external,
  // Status
  output logic [11:0] config_word,
  output logic [3:0] fifo_level
);
  // ************************************************************
  // Pin edges
  // ************************************************************
  logic sclk_q;
  logic cs_q;
  logic fs_q;
  logic trg_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      fs_q <= 1'b0;
      trg_q <= 1'b1;
    end else begin
      sclk_q <= sclk;
      cs_q <= cs_n;
      fs_q <= frame_sync_in;
      trg_q <= ext_sample_trigger_n;
    end
  end
  logic sclk_rise;
  logic sclk_fall;
  logic frame_start;
  logic trg_rise;
  logic trg_fall;
  assign sclk_rise = sclk && !sclk_q;
  assign sclk_fall = !sclk && sclk_q;
  assign frame_start = (cs_q && !cs_n) || (frame_sync_in && !fs_q);
  assign trg_rise = ext_sample_trigger_n && !trg_q;
  assign trg_fall = !ext_sample_trigger_n && trg_q;

  // ************************************************************
  // Command word receiver
  // ************************************************************
  logic [4:0] bit_cnt;
  logic [15:0] rx_shift;
  logic word_done;
  logic [15:0] rx_word;
  logic [3:0] cmd;
  assign word_done = sclk_rise && !cs_n && bit_cnt == asf_pkg::WORD_LAST;
  assign rx_word = {rx_shift[14:0], sdi};
  assign cmd = rx_word[15:12];
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt <= '0;
      rx_shift <= '0;
    end else if (frame_start) begin
      bit_cnt <= '0;
    end else if (sclk_rise && !cs_n) begin
      rx_shift <= rx_word;
      bit_cnt <= word_done ? 5'h00 : bit_cnt + 5'h01;
    end
  end
  logic is_select;
  logic is_read;
  logic soft_pd_cmd;
  assign is_select = word_done && !cmd[3];
  assign is_read = cmd == asf_pkg::CMD_READ_FIFO;
  assign soft_pd_cmd = word_done && rx_word == asf_pkg::WORD_SOFT_PD; // RULE_14

  // ************************************************************
  // Configuration
  // ************************************************************
  logic [1:0] mode;
  logic single;
  logic ext_samp;
  assign mode = config_word[asf_pkg::CF_MODE +: 2]; // RULE_20
  assign single = mode == asf_pkg::MODE_SINGLE;
  assign ext_samp = config_word[asf_pkg::CF_EXT];
  assign ref_level_4v = config_word[asf_pkg::CF_REF4]; // RULE_19
  assign ref_external = config_word[asf_pkg::CF_REFEXT]; // RULE_19
  asf_pkg::asf_pwr_t pwr;
  logic cfg_write;
  assign cfg_write = word_done && cmd == asf_pkg::CMD_WRITE_CFG
    && pwr != asf_pkg::PWR_HARD;
  // Power-down never touches this register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) config_word <= asf_pkg::CFG_RESET;
    else if (cfg_write) config_word <= rx_word[11:0]; // RULE_01 RULE_17
  end

  // ************************************************************
  // Power management
  // ************************************************************
  logic wake;
  logic conv_end;
  logic pd_enter;
  logic [19:0] warm_cnt;
  assign wake = !cs_n || frame_sync_in || !ext_sample_trigger_n;
  assign pd_enter = (!hw_powerdown_n && pwr != asf_pkg::PWR_HARD)
    || (soft_pd_cmd && pwr != asf_pkg::PWR_HARD);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pwr <= asf_pkg::PWR_ACTIVE;
      warm_cnt <= '0;
    end else if (!hw_powerdown_n) begin
      pwr <= asf_pkg::PWR_HARD; // RULE_15
    end else if (soft_pd_cmd) begin
      pwr <= asf_pkg::PWR_SOFT; // RULE_14
    end else begin
      case (pwr)
        asf_pkg::PWR_ACTIVE: if (conv_end) pwr <= asf_pkg::PWR_AUTO; // RULE_12
        asf_pkg::PWR_AUTO: if (wake) pwr <= asf_pkg::PWR_ACTIVE;
        asf_pkg::PWR_HARD, asf_pkg::PWR_SOFT: begin
          // Only fresh activity wakes from software power-down; the frame that sent 8000h is still low
          if (pwr == asf_pkg::PWR_HARD || frame_start || trg_fall) begin // RULE_16
            pwr <= ref_external ? asf_pkg::PWR_ACTIVE : asf_pkg::PWR_WARM;
            warm_cnt <= '0;
          end
        end
        asf_pkg::PWR_WARM: begin
          warm_cnt <= warm_cnt + 20'h00001;
          if (32'(warm_cnt) >= WARMUP_CYCLES - 1) begin
            pwr <= asf_pkg::PWR_ACTIVE; // RULE_15 RULE_16
          end
        end
        default: pwr <= asf_pkg::PWR_ACTIVE;
      endcase
    end
  end
  logic can_convert;
  // Wake from auto power-down is combinational, well inside half an SCLK
  // The pin gates power at once, without waiting for a clock edge
  assign analog_powered = hw_powerdown_n && (pwr == asf_pkg::PWR_ACTIVE
    || (pwr == asf_pkg::PWR_AUTO && wake)); // RULE_13 RULE_15
  assign ref_powered = hw_powerdown_n && (pwr == asf_pkg::PWR_ACTIVE
    || pwr == asf_pkg::PWR_AUTO || pwr == asf_pkg::PWR_WARM); // RULE_12
  assign can_convert = pwr == asf_pkg::PWR_ACTIVE || pwr == asf_pkg::PWR_AUTO;

  // ************************************************************
  // Sampling trigger and channel sequence
  // ************************************************************
  logic conv_busy;
  logic armed;
  logic sweep_stop;
  logic [1:0] sweep_idx;
  logic [2:0] sel_chan;
  logic start_req;
  logic conv_start;
  logic [2:0] seq_chan;
  function automatic logic [2:0] sweep_chan(input logic [1:0] seq,
                                            input logic [1:0] idx);
    sweep_chan = asf_pkg::SWEEP_TAB[{seq, idx} * 3 +: 3];
  endfunction : sweep_chan
  assign seq_chan = sweep_chan(config_word[asf_pkg::CF_SEQ +: 2], sweep_idx);
  // Extended sampling in FIFO modes starts only while chip select is high
  assign start_req = ext_samp
    ? trg_rise && (single ? armed : cs_n && !sweep_stop) // RULE_02
    : is_select && !(mode == asf_pkg::MODE_SWEEP && sweep_stop);
  assign conv_start = start_req && !conv_busy && can_convert;
  assign sampling = ext_samp ? !ext_sample_trigger_n && cs_n // RULE_04
    : !cs_n && bit_cnt >= asf_pkg::SAMPLE_BIT;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      armed <= 1'b0;
      sel_chan <= '0;
    end else begin
      if (is_select) sel_chan <= cmd[2:0];
      if (is_select && single && ext_samp) armed <= 1'b1; // RULE_02
      else if (conv_start || cfg_write) armed <= 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sweep_idx <= '0;
      sweep_stop <= 1'b0;
      mux_channel <= '0;
    end else if (pd_enter || cfg_write) begin
      sweep_idx <= '0; // RULE_17
      sweep_stop <= 1'b0;
    end else if (conv_start) begin
      if (mode[1]) begin
        mux_channel <= seq_chan; // RULE_07
        sweep_idx <= sweep_idx + 2'h1;
        sweep_stop <= sweep_idx == 2'h3;
      end else begin
        mux_channel <= is_select ? cmd[2:0] : sel_chan; // RULE_07
      end
    end
  end

  // ************************************************************
  // Conversion clock and timing
  // ************************************************************
  logic [3:0] osc_cnt;
  logic [1:0] div_cnt;
  logic [1:0] clk_sel;
  logic [1:0] div_last;
  logic conv_tick;
  logic [3:0] conv_cnt;
  logic res_pending;
  logic res_push;
  logic fifo_ready;
  assign clk_sel = config_word[asf_pkg::CF_CLK +: 2];
  assign div_last = clk_sel == 2'h3 ? 2'h3 : clk_sel == 2'h2 ? 2'h1 : 2'h0;
  assign conv_tick = clk_sel == 2'h0
    ? osc_cnt == 4'(asf_pkg::OSC_CYC - 1) // RULE_09
    : sclk_rise && div_cnt == div_last; // RULE_10
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      osc_cnt <= '0;
      div_cnt <= '0;
    end else if (!conv_busy) begin
      osc_cnt <= '0;
      div_cnt <= '0;
    end else begin
      osc_cnt <= conv_tick && clk_sel == 2'h0 ? 4'h0 : osc_cnt + 4'h1;
      if (sclk_rise) div_cnt <= div_cnt == div_last ? 2'h0 : div_cnt + 2'h1;
    end
  end
  assign conv_end = conv_busy && !res_pending && conv_tick
    && conv_cnt == asf_pkg::CONV_LAST; // RULE_09
  // A full FIFO stalls the converter until the host drains it
  // A result that meets a power-down is dropped with the rest
  assign res_push = res_pending && fifo_ready && !pd_enter; // RULE_18
  assign converting = conv_busy && !res_pending;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      conv_busy <= 1'b0;
      conv_cnt <= '0;
      res_pending <= 1'b0;
    end else if (pd_enter) begin
      conv_busy <= 1'b0;
      res_pending <= 1'b0;
    end else if (conv_start) begin
      conv_busy <= 1'b1;
      conv_cnt <= '0;
    end else if (conv_end) begin
      res_pending <= 1'b1;
    end else if (res_push) begin
      conv_busy <= 1'b0;
      res_pending <= 1'b0;
    end else if (converting && conv_tick) begin
      conv_cnt <= conv_cnt + 4'h1;
    end
  end

  // ************************************************************
  // Result FIFO, threshold and interrupt
  // ************************************************************
  logic flush;
  logic drop_pending;
  logic pop;
  logic head_valid;
  logic [11:0] head;
  logic [3:0] thr;
  logic int_flag;
  logic svc;
  logic read_stream;
  assign flush = pd_enter || (drop_pending && res_push); // RULE_18 RULE_23
  asf_fifo #(.W(asf_pkg::FIFO_W), .D(asf_pkg::FIFO_D)) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .flush(flush),
    .in_valid(res_pending && !pd_enter),
    .in_ready(fifo_ready),
    .in_data(adc_result),
    .out_valid(head_valid),
    .out_ready(pop),
    .out_data(head),
    .count(fifo_level)
  ); // RULE_05
  always_comb begin
    case (config_word[asf_pkg::CF_THR +: 2])
      2'h0: thr = 4'h8;
      2'h1: thr = 4'h6;
      2'h2: thr = 4'h4; // RULE_06
      default: thr = 4'h2;
    endcase
    if (single) thr = 4'h1; // RULE_08
  end
  assign pop = svc && word_done && is_read; // RULE_22
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      int_flag <= 1'b0;
    end else if (res_push && (flush ? 4'h1 : fifo_level + 4'h1) == thr) begin
      int_flag <= 1'b1; // RULE_06
    end else if (frame_start || flush) begin
      int_flag <= 1'b0; // RULE_24
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      svc <= 1'b0;
      read_stream <= 1'b0;
      drop_pending <= 1'b0;
    end else begin
      if (frame_start) svc <= head_valid && (int_flag || read_stream);
      else if (word_done) svc <= 1'b0;
      if (word_done) read_stream <= is_read && head_valid;
      if (svc && word_done && !is_read) drop_pending <= 1'b1; // RULE_23
      else if (trg_fall && int_flag) drop_pending <= 1'b1; // RULE_23
      else if (flush) drop_pending <= 1'b0;
    end
  end

  // ************************************************************
  // Serial output and completion pin
  // ************************************************************
  logic [15:0] tx_shift;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_shift <= '0;
    end else if (frame_start) begin
      // Head goes out before the command is even decoded
      tx_shift <= head_valid && (int_flag || read_stream)
        ? {head, 4'h0} : '0; // RULE_22
    end else if (sclk_rise && !cs_n && bit_cnt == 5'h03
                 && rx_word[15:12] == asf_pkg::CMD_READ_CFG && !svc) begin
      tx_shift <= {config_word, 4'h0};
    end else if (sclk_fall && !cs_n) begin
      tx_shift <= {tx_shift[14:0], 1'b0};
    end
  end
  assign sdo = tx_shift[15];
  assign sdo_oe = !cs_n;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) completion_n <= 1'b1;
    else if (single && config_word[asf_pkg::CF_EOC])
      completion_n <= !conv_busy; // RULE_21
    else completion_n <= !int_flag; // RULE_21
  end
endmodule : asf_seq

// File: testbench/asf_host.sv
// Host serial port model driving the converter's frame pins
`timescale 1ns/1ps
module asf_host (
  // Clock
  input wire logic mclk,
  // Serial port
  input wire logic sdo,
  output logic sclk,
  output logic cs_n,
  output logic frame_sync_in,
  output logic sdi
);
  // 6.25 MHz transfer clock; too fast to be an undivided conversion clock
  localparam int HALF = 4;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    frame_sync_in = 1'b0;
    sdi = 1'b0;
  end
  task automatic xfer(input logic [15:0] w, input logic fs,
                      output logic [15:0] r);
    int i;
    @(posedge mclk);
    cs_n <= 1'b0;
    frame_sync_in <= fs;
    repeat (HALF) @(posedge mclk);
    frame_sync_in <= 1'b0;
    for (i = 15; i >= 0; i--) begin
      sdi <= w[i];
      repeat (HALF) @(posedge mclk);
      sclk <= 1'b1;
      // Sample mid-way through the high phase, sdo moves after a fall or after the fourth rise of a config read
      repeat (2) @(posedge mclk);
      r[i] = sdo;
      repeat (HALF - 2) @(posedge mclk);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge mclk);
    cs_n <= 1'b1;
    // A released data line must not keep showing the last bit
    sdi <= ~sdi;
  endtask : xfer
endmodule : asf_host

// File: testbench/asf_seq_monitor.sv
// Port-level assertion checker for the converter sequencer
`timescale 1ns/1ps
module asf_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Host pins
  input wire logic cs_n,
  input wire logic hw_powerdown_n,
  // Observed outputs
  input wire logic completion_n,
  input wire logic converting,
  input wire logic analog_powered,
  input wire logic ref_powered,
  input wire logic [11:0] config_word,
  input wire logic [3:0] fifo_level
);
  logic [8:0] conv_cnt;
  logic [3:0] thr_n;
  // Threshold codes 00..11 mean 8, 6, 4 and 2 entries
  assign thr_n = 4'h8 - {1'b0, config_word[1:0], 1'b0};
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      conv_cnt <= 9'h000;
    end else if (converting) begin
      conv_cnt <= conv_cnt + 9'h001;
    end else begin
      conv_cnt <= 9'h000;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ********************************************************************
  // Assertions
  // ********************************************************************
  AST_CFG_QUIET: assert property (
    $changed(config_word) |-> !converting && $stable(fifo_level))
    else $error("config write disturbed conversion state");
  // First tick may be partial, so a window of one tick is allowed
  AST_CONV_LEN: assert property (
    $fell(converting) && config_word[11:10] == 2'h0 && hw_powerdown_n
    |-> conv_cnt >= 9'h0AA && conv_cnt <= 9'h0B8)
    else $error("conversion length is not fourteen ticks");
  AST_AUTO_PD: assert property (
    $fell(converting) && hw_powerdown_n
    |-> ##[0:2] (!analog_powered && ref_powered))
    else $error("no auto power-down after conversion");
  AST_WAKE: assert property (
    $fell(cs_n) && hw_powerdown_n && ref_powered && !analog_powered
    |-> ##[0:4] analog_powered)
    else $error("late wake from auto power-down");
  AST_PD_FLUSH: assert property (
    $fell(ref_powered) |-> ##[0:2] fifo_level == 4'h0)
    else $error("power-down left results stored");
  AST_HW_PD: assert property (
    !hw_powerdown_n |-> !analog_powered && !ref_powered)
    else $error("power-down pin did not power down");
  AST_CFG_KEEP: assert property (
    !ref_powered |-> $stable(config_word))
    else $error("config changed while powered down");
  AST_EOC: assert property (
    $rose(converting) && config_word[6:5] == 2'h0 && config_word[2]
    |-> ##[0:1] !completion_n)
    else $error("end of conversion not signalled");
  AST_THRESH: assert property (
    config_word[6:5] != 2'h0 && $changed(fifo_level) && fifo_level == thr_n
    |-> ##[0:1] !completion_n)
    else $error("threshold reached without interrupt");
  AST_DEPTH1: assert property (
    config_word[6:5] == 2'h0 |-> fifo_level <= 4'h1)
    else $error("single shot stored more than one result");
endmodule : asf_monitor

bind asf_seq asf_monitor u_mon (.mclk(mclk), .nrst(nrst), .cs_n(cs_n),
  .hw_powerdown_n(hw_powerdown_n), .completion_n(completion_n),
  .converting(converting), .analog_powered(analog_powered),
  .ref_powered(ref_powered), .config_word(config_word),
  .fifo_level(fifo_level));

// File: testbench/asf_seq_tb.sv
// Self-checking bench of the converter sequencer
`timescale 1ns/1ps
module asf_seq_tb;
  localparam int WARM = 20;
  logic mclk, nrst, ext_sample_trigger_n, hw_powerdown_n;
  logic sclk, cs_n, frame_sync_in, sdi, sdo, sdo_oe, completion_n;
  logic sampling, converting, analog_powered, ref_powered;
  logic ref_level_4v, ref_external;
  logic [11:0] adc_result, config_word;
  logic [2:0] mux_channel;
  logic [3:0] fifo_level;
  logic [15:0] rd;
  logic [13:0] rows [4];
  int n_mismatch, comparisons, k;
  asf_seq #(.WARMUP_CYCLES(WARM)) dut (.mclk(mclk), .nrst(nrst),
    .sclk(sclk), .cs_n(cs_n), .frame_sync_in(frame_sync_in), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .ext_sample_trigger_n(ext_sample_trigger_n),
    .hw_powerdown_n(hw_powerdown_n), .completion_n(completion_n),
    .adc_result(adc_result), .mux_channel(mux_channel),
    .sampling(sampling), .converting(converting),
    .analog_powered(analog_powered), .ref_powered(ref_powered),
    .ref_level_4v(ref_level_4v), .ref_external(ref_external),
    .config_word(config_word), .fifo_level(fifo_level));
  asf_host u_host (.mclk(mclk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n),
    .frame_sync_in(frame_sync_in), .sdi(sdi));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic put(input logic [15:0] w, input logic fs);
    u_host.xfer(w, fs, rd);
    cyc(3);
  endtask : put
  // Bounded waits, so a missing conversion is reported and not hung on
  task automatic conv(input logic [2:0] ch);
    int t;
    t = 0;
    while (converting !== 1'b1 && t < 300) begin
      cyc(1);
      t++;
    end
    chk(converting, 1'b1);
    chk(mux_channel, ch);
    while (converting === 1'b1 && t < 600) begin
      cyc(1);
      t++;
    end
    chk(converting, 1'b0);
    cyc(3);
  endtask : conv
  task automatic test_done;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    cyc(60000);
    n_mismatch++;
    test_done;
  end
  // ********************************************************************
  // Tests
  // ********************************************************************
  initial begin
    nrst = 1'b0;
    ext_sample_trigger_n = 1'b1;
    hw_powerdown_n = 1'b1;
    adc_result = 12'hA5C;
    n_mismatch = 0;
    comparisons = 0;
    rows = '{{12'h080, 2'h2}, {12'h120, 2'h1}, {12'h1C0, 2'h3},
             {12'h060, 2'h0}};
    cyc(12);
    nrst <= 1'b1;
    cyc(2);
    chk({config_word, fifo_level}, 16'h0000);
    chk({completion_n, analog_powered}, 2'h3);
    for (k = 0; k < 4; k++) begin
      put({asf_pkg::CMD_WRITE_CFG, rows[k][13:2]}, k[0]);
      chk(config_word, rows[k][13:2]);
      chk({ref_level_4v, ref_external}, rows[k][1:0]);
      chk({converting, completion_n, fifo_level}, 16'h0010);
    end
    // Single shot with threshold bits set: they must be ignored
    put({asf_pkg::CMD_WRITE_CFG, 12'h003}, 1'b0);
    put(16'h3000, 1'b1);
    conv(3'h3);
    chk({fifo_level, completion_n}, 5'h02);
    chk({analog_powered, ref_powered}, 2'h1);
    put({asf_pkg::CMD_READ_FIFO, 12'h000}, 1'b0);
    chk(rd, 16'hA5C0);
    chk({fifo_level, completion_n}, 5'h01);
    adc_result <= 12'h3C1;
    put({asf_pkg::CMD_WRITE_CFG, 12'h204}, 1'b0);
    put(16'h1000, 1'b0);
    cyc(20);
    chk(converting, 1'b0);
    ext_sample_trigger_n <= 1'b0;
    cyc(4);
    chk(sampling, 1'b1);
    ext_sample_trigger_n <= 1'b1;
    conv(3'h1);
    put(16'hE000, 1'b0);
    chk(rd, 16'h3C10);
    // Repeat mode, half threshold; fifth select is not a read
    put({asf_pkg::CMD_WRITE_CFG, 12'h022}, 1'b0);
    for (k = 0; k < 5; k++) begin
      adc_result <= 12'h100 + k[11:0];
      put(16'h5000, k[0]);
      conv(3'h5);
      chk(fifo_level, k < 4 ? k + 1 : 1);
      chk(completion_n, k != 3);
    end
    put(16'hE000, 1'b0);
    chk(rd, 16'h0000);
    chk(fifo_level, 4'h1);
    // Repeated sweep fills all eight entries, then a slow host drains
    put({asf_pkg::CMD_WRITE_CFG, 12'h060}, 1'b0);
    for (k = 0; k < 8; k++) begin
      adc_result <= 12'h200 + k[11:0];
      put(16'h0000, 1'b0);
      conv({1'b0, k[1:0]});
    end
    chk({fifo_level, completion_n}, 5'h10);
    for (k = 0; k < 8; k++) begin
      put(16'hE000, 1'b0);
      chk(rd, {12'h200 + k[11:0], 4'h0});
      cyc(10);
    end
    chk({fifo_level, completion_n}, 5'h01);
    put(16'h0000, 1'b0);
    conv(3'h0);
    put(asf_pkg::WORD_SOFT_PD, 1'b1);
    chk({analog_powered, ref_powered, fifo_level}, 16'h0000);
    chk(config_word, 12'h060);
    put(16'h0000, 1'b0);
    conv(3'h0);
    chk(ref_powered, 1'b1);
    hw_powerdown_n <= 1'b0;
    #1;
    chk({analog_powered, ref_powered}, 2'h0);
    cyc(2);
    chk(fifo_level, 4'h0);
    hw_powerdown_n <= 1'b1;
    cyc(5);
    chk(analog_powered, 1'b0);
    cyc(WARM + 5);
    chk({analog_powered, ref_powered}, 2'h3);
    put(16'h0000, 1'b0);
    conv(3'h0);
    test_done;
  end
endmodule : asf_seq_tb
